// ---- design/ldcb_pkg.sv ----
package ldcb_pkg;
  // ====
  // register map
  // ====
  localparam logic [31:0] ADDR_DEVICE_CONTROL = 32'h0000_0000; // device control word
  localparam logic [31:0] ADDR_LINK_STATUS    = 32'h0000_0008; // resolved link state (read only)
  localparam logic [31:0] ADDR_MODE_CONFIG    = 32'h0000_0010; // mode and autoneg config
  localparam logic [11:0] ADDR_DECODE_MASK    = 12'hffc;       // word-aligned decode window

  // ====
  // device control field positions
  // ====
  localparam int BIT_FULL_DUPLEX    = 0;
  localparam int BIT_LINK_RESET     = 3;
  localparam int BIT_AUTO_SPEED_EN  = 5;
  localparam int BIT_SET_LINK_UP    = 6;
  localparam int BIT_FORCE_DUPLEX   = 12;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_1069; // bits 0,3,5,6,12 are stored

  // ====
  // status field positions
  // ====
  localparam int STS_LINK_UP     = 0;
  localparam int STS_FULL_DUPLEX = 1;
  localparam int STS_SPEED_LO    = 2;
  localparam int STS_TXRX_HALT   = 4;
  localparam int STS_AN_ACTIVE   = 5;
  localparam int STS_LEDS_LO     = 6;

  // ====
  // mode config field positions
  // ====
  localparam int CFG_TBI_MODE   = 0;
  localparam int CFG_TX_AUTONEG = 1;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0000_0003;

  // ====
  // reset values and speed codes
  // ====
  localparam logic       RST_FULL_DUPLEX = 1'b1;
  localparam logic       RST_LINK_RESET  = 1'b1;
  localparam logic [1:0] SPEED_1000      = 2'b10;
  localparam logic [1:0] SPEED_DEFAULT   = 2'b10;

  // ====
  // autonegotiation sequencer
  // ====
  typedef enum logic [1:0]
  {
    AN_IDLE    = 2'b00,
    AN_HELD    = 2'b01,
    AN_RUNNING = 2'b10,
    AN_DONE    = 2'b11
  } ldcb_an_state_t;

  localparam int        AN_TIME_NS    = 40;  // nominal restart pulse length
  localparam int        CLK_PERIOD_NS = 4;
  localparam logic [3:0] AN_CYCLES    = 4'((AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ---- design/ldcb_resolve.sv ----
`timescale 1ns/1ps
// ====
// combinational link and duplex resolution
// ====
module ldcb_resolve
(
  input  wire logic       tenBitMode,     // serdes / tbi mode selected
  input  wire logic       txAutonegEn,    // tx autoneg enable
  input  wire logic       fullDuplexBit,  // software duplex choice
  input  wire logic       forceDuplexBit, // software duplex override
  input  wire logic       setLinkUpBit,   // software link-up
  input  wire logic       autoSpeedEn,    // auto speed detect enable
  input  wire logic       linkResetBit,   // link reset held
  input  wire logic       anComplete,     // autoneg finished
  input  wire logic       anFullDuplex,   // autoneg duplex outcome
  input  wire logic       lossOfSignal,   // receiver sync lost
  input  wire logic       phyLinkInd,     // phy link indication
  input  wire logic       phyFullDuplex,  // duplex reported by phy
  input  wire logic [1:0] phySpeed,       // speed reported by phy
  input  wire logic [1:0] swSpeed,        // software speed
  output logic            linkUp,         // resolved link
  output logic            fullDuplex,     // resolved duplex
  output logic [1:0]      speed,          // resolved speed
  output logic            txRxHalt        // halt both directions
);
  // ----
  // resolution logic
  // ----
  always_comb
  begin
    txRxHalt = linkResetBit;
    speed    = swSpeed;
    if (tenBitMode)
    begin
      speed = ldcb_pkg::SPEED_1000;
      if (txAutonegEn)
      begin
        // set-link-up ignored and software duplex disregarded
        linkUp     = anComplete && !lossOfSignal;
        fullDuplex = anFullDuplex;
      end
      else
      begin
        // forced link bypasses configuration once sync exists
        linkUp     = setLinkUpBit && !lossOfSignal;
        fullDuplex = fullDuplexBit;
      end
    end
    else
    begin
      linkUp = setLinkUpBit && phyLinkInd;
      if (autoSpeedEn && setLinkUpBit)
      begin
        speed = phySpeed;
      end
      // duplex follows the bit only under override
      fullDuplex = forceDuplexBit ? fullDuplexBit : phyFullDuplex;
    end
    if (linkResetBit)
    begin
      linkUp = 1'b0;
    end
  end
endmodule

// ---- design/ldcb_top.sv ----
// Overview of operation
// - full-duplex bit decides duplex under force-duplex
// - serdes with autoneg ignores full-duplex bit
// - link reset halts transmit and receive
// - link reset resets logic; release starts autoneg (code resets logic only for serdes with autoneg)
// - link reset starts one, loadable from eeprom
// - auto speed detect configures speed itself
// - auto speed needs link-up; ignored in serdes
// - serdes forced link-up once signal present
// - autoneg enabled makes set-link-up ignored
// - phy link seen only with set-link-up
// - set-link-up resets one if eeprom enables
// - leds dark until set-link-up is set
// - force-duplex selects full-duplex bit source
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module ldcb_top
(
  input  wire logic        clock,          // 250 mhz system clock
  input  wire logic        arst_n,         // async reset, active low
  // ahb-lite slave
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic        hready,         // bus ready in
  input  wire logic [31:0] hwdata,         // write data
  output logic [31:0]      hrdata,         // read data
  output logic             hreadyout,      // slave ready
  output logic             hresp,          // always okay
  // eeprom defaults, caught after reset release
  input  wire logic        eeLoadValid,    // eeprom words valid
  input  wire logic        eeFullDuplex,   // eeprom full-duplex default
  input  wire logic        eeLinkReset,    // eeprom link-reset default
  input  wire logic        eePowerMgmtEn,  // eeprom power management enable
  input  wire logic        eeSmbusEn,      // eeprom smbus enable
  // link side
  input  wire logic        lossOfSignal,   // serdes loss of signal
  input  wire logic        phyLinkInd,     // phy link indication
  input  wire logic        phyFullDuplex,  // phy duplex
  input  wire logic [1:0]  phySpeed,       // phy speed
  input  wire logic        anPartnerDone,  // partner finished autoneg
  input  wire logic        anPartnerFd,    // partner duplex ability
  output logic             linkUp,         // resolved link up
  output logic             fullDuplex,     // resolved duplex
  output logic [1:0]      speed,          // resolved speed
  output logic             txRxHalt,       // halt tx and rx
  output logic             anRestart,      // autoneg restart pulse
  output logic             linkCtrlReset,  // link control logic reset
  output logic             ledLink,        // link led
  output logic             ledActivity,    // activity led
  output logic [1:0]      ledSpeed        // speed leds
);
  // ==========================================================================
  // register state
  // ==========================================================================
  logic [31:0] ctrl_ff, nxt_ctrl;           // device control word
  logic [31:0] cfg_ff, nxt_cfg;             // mode config word
  logic        eeDone_ff, nxt_eeDone;       // eeprom defaults applied
  logic        wrPend_ff, nxt_wrPend;       // write data phase pending
  logic        rdPend_ff, nxt_rdPend;       // read data phase pending
  logic [31:0] addr_ff, nxt_addr;           // latched address
  logic [31:0] rdata_ff, nxt_rdata;         // read data register

  // ==========================================================================
  // autoneg sequencer state
  // ==========================================================================
  ldcb_pkg::ldcb_an_state_t anState_ff, nxt_anState;
  logic [3:0]  anCnt_ff, nxt_anCnt;         // restart pulse counter
  logic        anFd_ff, nxt_anFd;           // captured autoneg duplex

  // ==========================================================================
  // resolved link values
  // ==========================================================================
  logic        resLink;                     // combinational link
  logic        resFd;                       // combinational duplex
  logic [1:0]  resSpeed;                    // combinational speed
  logic        resHalt;                     // combinational halt
  logic [31:0] statusWord;                  // read-only status
  logic        addrPhase;                   // valid address phase
  logic        serdesAn;                    // serdes with autoneg

  // decode shared by read and write paths
  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    hit = (a[31:12] == base[31:12]) && ((a[11:0] & ldcb_pkg::ADDR_DECODE_MASK) == base[11:0]);
  endfunction

  assign addrPhase = hsel && hready && htrans[1];
  assign serdesAn  = cfg_ff[ldcb_pkg::CFG_TBI_MODE] && cfg_ff[ldcb_pkg::CFG_TX_AUTONEG];
  assign hreadyout = 1'b1;                  // zero wait states
  assign hresp     = 1'b0;                  // okay only
  assign hrdata    = rdata_ff;

  // ==========================================================================
  // resolver
  // ==========================================================================
  ldcb_resolve u_resolve
  (
    .tenBitMode     (cfg_ff[ldcb_pkg::CFG_TBI_MODE]),
    .txAutonegEn    (cfg_ff[ldcb_pkg::CFG_TX_AUTONEG]),
    .fullDuplexBit  (ctrl_ff[ldcb_pkg::BIT_FULL_DUPLEX]),
    .forceDuplexBit (ctrl_ff[ldcb_pkg::BIT_FORCE_DUPLEX]),
    .setLinkUpBit   (ctrl_ff[ldcb_pkg::BIT_SET_LINK_UP]),
    .autoSpeedEn    (ctrl_ff[ldcb_pkg::BIT_AUTO_SPEED_EN]),
    .linkResetBit   (ctrl_ff[ldcb_pkg::BIT_LINK_RESET]),
    .anComplete     (anState_ff == ldcb_pkg::AN_DONE),
    .anFullDuplex   (anFd_ff),
    .lossOfSignal   (lossOfSignal),
    .phyLinkInd     (phyLinkInd),
    .phyFullDuplex  (phyFullDuplex),
    .phySpeed       (phySpeed),
    .swSpeed        (ldcb_pkg::SPEED_DEFAULT),
    .linkUp         (resLink),
    .fullDuplex     (resFd),
    .speed          (resSpeed),
    .txRxHalt       (resHalt)
  );

  // ==========================================================================
  // register file and eeprom load
  // ==========================================================================
  // data phase is one cycle after the address; reads are served from a
  // registered snapshot so hrdata is a flop output
  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_cfg    = cfg_ff;
    nxt_eeDone = eeDone_ff;
    nxt_wrPend = addrPhase && hwrite;
    nxt_rdPend = addrPhase && !hwrite;
    nxt_addr   = addrPhase ? haddr : addr_ff;
    nxt_rdata  = rdata_ff;
    // eeprom defaults land once, after reset release
    if (!eeDone_ff && eeLoadValid)
    begin
      nxt_eeDone = 1'b1;
      nxt_ctrl[ldcb_pkg::BIT_FULL_DUPLEX] = eeFullDuplex;
      nxt_ctrl[ldcb_pkg::BIT_LINK_RESET]  = eeLinkReset;
      nxt_ctrl[ldcb_pkg::BIT_SET_LINK_UP] = eePowerMgmtEn || eeSmbusEn;
    end
    // software write; reserved bits are not stored and read back zero
    if (wrPend_ff)
    begin
      if (hit(addr_ff, ldcb_pkg::ADDR_DEVICE_CONTROL))
      begin
        nxt_ctrl = hwdata & ldcb_pkg::CTRL_WRITE_MASK;
      end
      else if (hit(addr_ff, ldcb_pkg::ADDR_MODE_CONFIG))
      begin
        nxt_cfg = hwdata & ldcb_pkg::CFG_WRITE_MASK;
      end
    end
    // read snapshot taken at the address phase; unmapped reads return zero
    if (addrPhase && !hwrite)
    begin
      if (hit(haddr, ldcb_pkg::ADDR_DEVICE_CONTROL))
      begin
        nxt_rdata = ctrl_ff;
      end
      else if (hit(haddr, ldcb_pkg::ADDR_LINK_STATUS))
      begin
        nxt_rdata = statusWord;
      end
      else if (hit(haddr, ldcb_pkg::ADDR_MODE_CONFIG))
      begin
        nxt_rdata = cfg_ff;
      end
      else
      begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_ff   <= {31'h0000_0000, ldcb_pkg::RST_FULL_DUPLEX} |
                   (32'h0000_0001 << ldcb_pkg::BIT_LINK_RESET);
      cfg_ff    <= 32'h0000_0000;
      eeDone_ff <= 1'b0;
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= 32'h0000_0000;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      cfg_ff    <= nxt_cfg;
      eeDone_ff <= nxt_eeDone;
      wrPend_ff <= nxt_wrPend;
      rdPend_ff <= nxt_rdPend;
      addr_ff   <= nxt_addr;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ==========================================================================
  // autonegotiation sequencer
  // ==========================================================================
  // held while link reset is set; the falling edge of link reset starts
  // a fixed restart pulse, then waits for the partner to finish
  always_comb
  begin
    nxt_anState = anState_ff;
    nxt_anCnt   = anCnt_ff;
    nxt_anFd    = anFd_ff;
    if (!serdesAn)
    begin
      nxt_anState = ldcb_pkg::AN_IDLE;
      nxt_anCnt   = 4'h0;
    end
    else if (ctrl_ff[ldcb_pkg::BIT_LINK_RESET])
    begin
      nxt_anState = ldcb_pkg::AN_HELD;
      nxt_anCnt   = 4'h0;
    end
    else
    begin
      case (anState_ff)
        ldcb_pkg::AN_IDLE:
        begin
          nxt_anState = ldcb_pkg::AN_RUNNING;
        end
        ldcb_pkg::AN_HELD:
        begin
          // release of link reset starts the autoneg function
          nxt_anState = ldcb_pkg::AN_RUNNING;
          nxt_anCnt   = ldcb_pkg::AN_CYCLES;
        end
        ldcb_pkg::AN_RUNNING:
        begin
          if (anCnt_ff != 4'h0)
          begin
            nxt_anCnt = anCnt_ff - 4'h1;
          end
          else if (anPartnerDone)
          begin
            nxt_anState = ldcb_pkg::AN_DONE;
            nxt_anFd    = anPartnerFd;
          end
        end
        ldcb_pkg::AN_DONE:
        begin
          nxt_anState = ldcb_pkg::AN_DONE;
        end
        default:
        begin
          nxt_anState = ldcb_pkg::AN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      anState_ff <= ldcb_pkg::AN_IDLE;
      anCnt_ff   <= 4'h0;
      anFd_ff    <= 1'b0;
    end
    else
    begin
      anState_ff <= nxt_anState;
      anCnt_ff   <= nxt_anCnt;
      anFd_ff    <= nxt_anFd;
    end
  end

  // ==========================================================================
  // registered link outputs and leds
  // ==========================================================================
  logic       link_ff, fd_ff, halt_ff, anRst_ff, lcRst_ff;
  logic [1:0] speed_ff;
  logic [3:0] leds_ff, nxt_leds;            // link, activity, speed pair

  always_comb
  begin
    // leds stay dark until software or the eeprom load raises set-link-up
    nxt_leds = 4'h0;
    if (ctrl_ff[ldcb_pkg::BIT_SET_LINK_UP])
    begin
      nxt_leds = {resSpeed, resLink && !resHalt, resLink};
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_ff  <= 1'b0;
      fd_ff    <= 1'b0;
      speed_ff <= 2'b00;
      halt_ff  <= 1'b1;
      anRst_ff <= 1'b0;
      lcRst_ff <= 1'b1;
      leds_ff  <= 4'h0;
    end
    else
    begin
      link_ff  <= resLink;
      fd_ff    <= resFd;
      speed_ff <= resSpeed;
      halt_ff  <= resHalt;
      anRst_ff <= (anState_ff == ldcb_pkg::AN_RUNNING) && (anCnt_ff != 4'h0);
      lcRst_ff <= serdesAn && ctrl_ff[ldcb_pkg::BIT_LINK_RESET];
      leds_ff  <= nxt_leds;
    end
  end

  assign statusWord = {24'h00_0000, leds_ff[1:0], (anState_ff == ldcb_pkg::AN_RUNNING),
                       halt_ff, speed_ff, fd_ff, link_ff};
  assign linkUp        = link_ff;
  assign fullDuplex    = fd_ff;
  assign speed         = speed_ff;
  assign txRxHalt      = halt_ff;
  assign anRestart     = anRst_ff;
  assign linkCtrlReset = lcRst_ff;
  assign ledLink       = leds_ff[0];
  assign ledActivity   = leds_ff[1];
  assign ledSpeed      = leds_ff[3:2];
endmodule

// ---- bench/ldcb_top_asserts.sv ----
`timescale 1ns/1ps
// ====
// port-level checks of bus answer, link, halt, restart and led control
// ====
module ldcb_top_asserts
(
  input wire logic clock,         // system clock
  input wire logic arst_n,        // async reset, active low
  input wire logic hreadyout,     // slave ready
  input wire logic hresp,         // response
  input wire logic lossOfSignal,  // serdes loss of signal
  input wire logic phyLinkInd,    // phy link indication
  input wire logic linkUp,        // resolved link
  input wire logic txRxHalt,      // halt both directions
  input wire logic anRestart,     // autoneg restart pulse
  input wire logic linkCtrlReset, // link control reset
  input wire logic ledLink        // link led
);
  // all checks share one clock and one reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_halt_drops_link: assert property (txRxHalt |-> !linkUp)
    else $error("link up while halted");
  a_ctrl_reset_halts: assert property (linkCtrlReset |-> txRxHalt)
    else $error("link logic reset without halt");
  a_restart_ten_cycles: assert property ($rose(anRestart) |-> anRestart[*8] ##1 anRestart ##1 anRestart ##1 !anRestart)
    else $error("restart pulse length wrong");
  a_restart_after_release: assert property ($rose(anRestart) |-> !linkCtrlReset)
    else $error("restart while link reset held");
  a_restart_no_link: assert property (anRestart |-> !linkUp)
    else $error("link up during restart");
  a_no_signal_no_link: assert property (lossOfSignal && !phyLinkInd |=> !linkUp)
    else $error("link up without signal");
  a_led_needs_link: assert property (ledLink |-> linkUp)
    else $error("link led lit without link");
endmodule

bind ldcb_top ldcb_top_asserts u_asserts
(
  .clock(clock), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp),
  .lossOfSignal(lossOfSignal), .phyLinkInd(phyLinkInd), .linkUp(linkUp), .txRxHalt(txRxHalt),
  .anRestart(anRestart), .linkCtrlReset(linkCtrlReset), .ledLink(ledLink)
);

// ---- bench/ldcb_link_partner.sv ----
`timescale 1ns/1ps
// ====
// far-side model: phy or serdes link partner
// ====
module ldcb_link_partner
(
  input  wire logic       clock,         // system clock
  input  wire logic       arst_n,        // async reset, active low
  input  wire logic       anRestart,     // restart request from block
  input  wire logic       linkOk,        // bench: signal present
  input  wire logic       slowAn,        // bench: long negotiation
  input  wire logic       partnerFd,     // bench: partner duplex
  input  wire logic [1:0] partnerSpeed,  // bench: partner speed
  output logic            lossOfSignal,  // active high when no signal
  output logic            phyLinkInd,    // phy link indication
  output logic            phyFullDuplex, // phy duplex
  output logic [1:0]      phySpeed,      // phy speed
  output logic            anPartnerDone, // negotiation complete
  output logic            anPartnerFd    // negotiated duplex
);
  logic [5:0] anCount_ff;  // cycles left until done
  logic [5:0] nxt_anCount; // next count
  logic       done_ff;     // negotiation finished
  logic       nxt_done;    // next finished flag

  // ====
  // negotiation timer: restarts with every restart pulse, never done early
  // ====
  always_comb
  begin
    nxt_anCount = anCount_ff;
    nxt_done    = done_ff;
    if (anRestart)
    begin
      // slow answer gives the block time to show it waits
      nxt_anCount = slowAn ? 6'h1e : 6'h02;
      nxt_done    = 1'b0;
    end
    else if (anCount_ff != 6'h00)
    begin
      nxt_anCount = anCount_ff - 6'h01;
      nxt_done    = (anCount_ff == 6'h01);
    end
  end

  // registers only
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      anCount_ff <= 6'h00;
      done_ff    <= 1'b0;
    end
    else
    begin
      anCount_ff <= nxt_anCount;
      done_ff    <= nxt_done;
    end
  end

  // line levels follow the bench's link state
  assign lossOfSignal  = !linkOk;
  assign phyLinkInd    = linkOk;
  assign phyFullDuplex = partnerFd;
  assign phySpeed      = partnerSpeed;
  assign anPartnerDone = done_ff;
  assign anPartnerFd   = partnerFd;
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
// ====
// bench top: bus master, link partner, scenarios
// ====
module tb_top;
  logic        clock = 1'b0;           // 250 mhz
  logic        arst_n = 1'b0;          // reset, active low
  logic        hsel = 1'b0;            // bus select
  logic [31:0] haddr = 32'h0;          // bus address
  logic [1:0]  htrans = 2'b00;         // transfer type
  logic        hwrite = 1'b0;          // write strobe
  logic [2:0]  hsize = 3'h2;           // whole words only
  logic [31:0] hwdata = 32'h0;         // write data
  logic        eeValid = 1'b0;         // eeprom defaults valid
  logic [3:0]  eeBits = 4'h0;          // {pm, smbus, link reset, duplex}
  logic        linkOk = 1'b0;          // partner signal present
  logic        slowAn = 1'b0;          // partner slow
  logic        partnerFd = 1'b0;       // partner duplex
  logic [1:0]  partnerSpeed = 2'b10;   // partner speed
  wire         hready;                 // bus ready = slave ready
  logic [31:0] hrdata;                 // read data
  logic        hresp, lossOfSignal, phyLinkInd, phyFullDuplex, anPartnerDone, anPartnerFd;
  logic        linkUp, fullDuplex, txRxHalt, anRestart, linkCtrlReset, ledLink, ledActivity;
  logic [1:0]  speed, phySpeed, ledSpeed;
  logic [31:0] rd;                     // last read word
  int          failures = 0;
  int          checks = 0;
  logic [31:0] phyCtrl [5] = '{32'h0, 32'h1041, 32'h1040, 32'h0041, 32'h0061};
  logic [4:0]  phyExp [5] = '{5'b00100, 5'b11101, 5'b10101, 5'b10101, 5'b10011};

  always #2 clock = ~clock;

  ldcb_top dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .eeLoadValid(eeValid), .eeFullDuplex(eeBits[0]),
    .eeLinkReset(eeBits[1]), .eePowerMgmtEn(eeBits[3]), .eeSmbusEn(eeBits[2]),
    .lossOfSignal(lossOfSignal), .phyLinkInd(phyLinkInd), .phyFullDuplex(phyFullDuplex),
    .phySpeed(phySpeed), .anPartnerDone(anPartnerDone), .anPartnerFd(anPartnerFd), .linkUp(linkUp),
    .fullDuplex(fullDuplex), .speed(speed), .txRxHalt(txRxHalt), .anRestart(anRestart),
    .linkCtrlReset(linkCtrlReset), .ledLink(ledLink), .ledActivity(ledActivity), .ledSpeed(ledSpeed));

  ldcb_link_partner u_partner (.clock(clock), .arst_n(arst_n), .anRestart(anRestart), .linkOk(linkOk),
    .slowAn(slowAn), .partnerFd(partnerFd), .partnerSpeed(partnerSpeed), .lossOfSignal(lossOfSignal),
    .phyLinkInd(phyLinkInd), .phyFullDuplex(phyFullDuplex), .phySpeed(phySpeed),
    .anPartnerDone(anPartnerDone), .anPartnerFd(anPartnerFd));

  // ====
  // report and compare helpers
  // ====
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp)
    begin
      failures++;
      $display("mismatch at %0t: word %h, wanted %h", $time, act, exp);
    end
  endtask

  task automatic check_bit(input logic act, input logic exp);
    check_word({31'h0, act}, {31'h0, exp});
  endtask

  // a hang on the bus ends the run through the report
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        failures++;
        final_report();
      end
      @(posedge clock);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    wait_ready();
    rd = hrdata;
  endtask

  // outputs lag a register or input change by one clock
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic reset_dut();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
  endtask

  // ====
  // scenarios
  // ====
  task automatic test_reset_map();
    bus_xfer(1'b0, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h0);
    check_word(rd, 32'h0000_0009);
    bus_xfer(1'b0, ldcb_pkg::ADDR_MODE_CONFIG, 32'h0);
    check_word(rd, 32'h0);
    check_bit(txRxHalt, 1'b1);
    bus_xfer(1'b1, 32'h0000_0040, 32'h5a5a_5a5a);
    bus_xfer(1'b0, 32'h0000_0040, 32'h0);
    check_word(rd, 32'h0);
    bus_xfer(1'b1, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'hffff_ffe9);
    bus_xfer(1'b0, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h0);
    check_word(rd, 32'h0000_1069);
    $display("test reset_map done");
  endtask

  // eeprom defaults: set-link-up only with power management or smbus
  task automatic test_eeprom();
    logic [3:0]  caseBits [3] = '{4'b1000, 4'b0111, 4'b0010};
    logic [31:0] caseExp [3] = '{32'h40, 32'h49, 32'h08};
    for (int i = 0; i < 3; i++)
    begin
      eeBits  <= caseBits[i];
      eeValid <= 1'b1;
      reset_dut();
      bus_xfer(1'b0, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h0);
      check_word(rd, caseExp[i]);
    end
    $display("test eeprom done");
  endtask

  // serdes with autoneg: release of link reset restarts negotiation
  task automatic test_autoneg();
    int n;
    linkOk    <= 1'b1;
    slowAn    <= 1'b1;
    partnerFd <= 1'b1;
    bus_xfer(1'b1, ldcb_pkg::ADDR_MODE_CONFIG, 32'h3);
    bus_xfer(1'b1, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h09);
    settle();
    check_bit(linkCtrlReset, 1'b1);
    check_bit(linkUp, 1'b0);
    bus_xfer(1'b1, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h40);
    n = 0;
    while (anRestart !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    while (anRestart === 1'b1 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check_word(32'(n), 32'(ldcb_pkg::AN_CYCLES));
    check_bit(linkUp, 1'b0);
    n = 0;
    while (linkUp !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check_bit(linkUp, 1'b1);
    check_bit(fullDuplex, 1'b1);
    check_bit(txRxHalt, 1'b0);
    $display("test autoneg done");
  endtask

  // serdes forced link: duplex from the register, speed detect ignored
  task automatic test_forced_serdes();
    partnerSpeed <= 2'b01;
    bus_xfer(1'b1, ldcb_pkg::ADDR_MODE_CONFIG, 32'h1);
    for (int fd = 0; fd < 2; fd++)
    begin
      bus_xfer(1'b1, ldcb_pkg::ADDR_DEVICE_CONTROL, 32'h60 | 32'(fd));
      settle();
      check_word({28'h0, linkUp, fullDuplex, speed}, {28'h0, 1'b1, 1'(fd), 2'b10});
    end
    bus_xfer(1'b0, ldcb_pkg::ADDR_LINK_STATUS, 32'h0);
    check_word(rd & 32'h13, 32'h03);
    linkOk <= 1'b0;
    settle();
    check_bit(linkUp, 1'b0);
    $display("test forced_serdes done");
  endtask

  // internal phy: link seen only with set-link-up, duplex override
  task automatic test_phy_mode();
    linkOk       <= 1'b1;
    partnerFd    <= 1'b0;
    partnerSpeed <= 2'b01;
    bus_xfer(1'b1, ldcb_pkg::ADDR_MODE_CONFIG, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      bus_xfer(1'b1, ldcb_pkg::ADDR_DEVICE_CONTROL, phyCtrl[i]);
      settle();
      check_word({27'h0, linkUp, fullDuplex, speed, ledLink}, {27'h0, phyExp[i]});
      check_word({29'h0, ledActivity, ledSpeed}, {29'h0, phyExp[i][0], phyExp[i][0] ? phyExp[i][2:1] : 2'b00});
    end
    $display("test phy_mode done");
  endtask

  // ====
  // main sequence and watchdog
  // ====
  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    test_reset_map();
    test_eeprom();
    test_autoneg();
    test_forced_serdes();
    test_phy_mode();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    $display("mismatch at %0t: run timeout", $time);
    failures++;
    final_report();
  end
endmodule
